// >>> udc_cfg.svh
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH

// word offsets inside one channel's register block
`define UDC_OFF_CTRL       3'h0
`define UDC_OFF_SIZE       3'h1
`define UDC_OFF_ADDR_LO    3'h2
`define UDC_OFF_ADDR_HI    3'h3
`define UDC_OFF_COUNT      3'h4
`define UDC_OFF_RELOAD_SZ  3'h5
`define UDC_OFF_RELOAD_LO  3'h6
`define UDC_OFF_RELOAD_HI  3'h7

// control register bit positions
`define UDC_BIT_RUN        0
`define UDC_BIT_HALT       1
`define UDC_BIT_RELOAD     2
`define UDC_BIT_OFLOW      3
`define UDC_BIT_END        4
`define UDC_BIT_CHAIN      5
`define UDC_BIT_SHORT      6
`define UDC_BIT_MISS_EN    7
`define UDC_BIT_LOST       8

// reset values and the one-byte count step
`define UDC_RST_WORD       16'h0000
`define UDC_RST_BIT        1'b0
`define UDC_ONE_BYTE       16'h0001

`endif

// >>> udc_pkg.sv
package udc_pkg;
    typedef logic [15:0] udc_word_t;
    typedef enum logic [1:0] {
        UDC_IDLE,
        UDC_MOVE,
        UDC_ZLP
    } udc_state_e;
    // option bits latched at start or reload
    typedef struct packed {
        logic short_pkt;
        logic chain;
        logic end_opt;
    } udc_opts_s;
endpackage : udc_pkg

// >>> udc_buf_if.sv
`timescale 1ns/1ps
interface udc_buf_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : udc_buf_if

// >>> udc_skid.sv
`timescale 1ns/1ps
// ****************************************
// two-entry buffer in the data path
// ****************************************
module udc_skid #(
    parameter int W = 8
) (
    input  wire logic clock,
    input  wire logic rst,
    udc_buf_if.dst    in_p,
    udc_buf_if.src    out_p
);
    logic [W-1:0] mem_reg [2];
    logic [W-1:0] mem_next [2];
    logic         rd_reg, rd_next, wr_reg, wr_next;
    logic [1:0]   cnt_reg, cnt_next;
    logic         push, pop;

    // depth two lets a receiver stall without losing a word
    always_comb begin
        push      = in_p.valid && (cnt_reg != 2'h2);
        pop       = out_p.ready && (cnt_reg != 2'h0);
        mem_next  = mem_reg;
        if (push) begin
            mem_next[wr_reg] = in_p.data;
        end
        wr_next  = push ? ~wr_reg : wr_reg;
        rd_next  = pop ? ~rd_reg : rd_reg;
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_reg <= 2'h0;
            rd_reg  <= 1'b0;
            wr_reg  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            rd_reg  <= rd_next;
            wr_reg  <= wr_next;
        end
        mem_reg <= mem_next;
    end

    assign in_p.ready  = (cnt_reg != 2'h2);
    assign out_p.valid = (cnt_reg != 2'h0);
    assign out_p.data  = mem_reg[rd_reg];
endmodule : udc_skid

// >>> udc_regfile.sv
`timescale 1ns/1ps
`include "udc_cfg.svh"
// ****************************************
// plain storage words of one channel block
// ****************************************
module udc_regfile
    import udc_pkg::*;
#(
    parameter int N = 3
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [N-1:0] we,
    input  wire udc_word_t    wdata [N],
    output udc_word_t         q [N]
);
    udc_word_t q_reg [N];
    udc_word_t q_next [N];

    // one generate loop, each word loaded on its own enable
    for (genvar i = 0; i < N; i++) begin : g_word
        always_comb begin
            q_next[i] = we[i] ? wdata[i] : q_reg[i];
        end
        always_ff @(posedge clock) begin
            if (rst) begin
                q_reg[i] <= `UDC_RST_WORD;
            end else begin
                q_reg[i] <= q_next[i];
            end
        end
        assign q[i] = q_reg[i];
    end
endmodule : udc_regfile

// >>> udc_channel.sv
`timescale 1ns/1ps
`include "udc_cfg.svh"
// Contract
// - each general endpoint gets its own channel; instantiate once per endpoint
// - every channel block uses the same word offsets from its base
// - offset 0 is control, offset 1 is transfer size in bytes
// - offsets 2 and 3 hold low and high byte address halves
// - offset 4 reports the bytes moved so far
// - offsets 5 to 7 hold reload size and reload address halves
// - the control word drives start, stop, reload and overflow
// - writing one to run latches control bits 4 to 6
// - bits 4 to 6 changes are ignored while a transfer runs
// - reload at completion relatches bits 4 to 6 and restarts at once
// - reload at end swaps working size and address with reload words
// - missed iso frame with error enable halts and sets lost flag
// - in, short control, full last packet: send zero length packet
// - out without chaining: packet above remaining bytes sets overflow
module udc_channel
    import udc_pkg::*;
#(
    parameter bit       IS_IN   = 1'b1,
    parameter int       MAX_PKT = 64
) (
    input  wire logic        clock,
    input  wire logic        rst,
    // register port, word addressed inside this block
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // endpoint side: one byte per beat
    input  wire logic        ep_valid,
    input  wire logic [7:0]  ep_data,
    output logic             ep_ready,
    input  wire logic        ep_pkt_end,
    input  wire logic [15:0] ep_pkt_len,
    input  wire logic        frame_missed,
    output logic             ep_count_clear,
    // memory side
    output logic             mem_valid,
    output logic [7:0]       mem_data,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_ready,
    // status
    output logic             busy
);
    // elaboration check: the packet counter compare is sixteen bits wide
    if (MAX_PKT < 1 || MAX_PKT > 1023) begin : g_bad_max_pkt
        $error("udc_channel: MAX_PKT out of range");
    end

    // ****************************************
    // storage words
    // ****************************************
    localparam int NW = 6;
    logic [NW-1:0] st_we;
    udc_word_t     st_wd [NW];
    udc_word_t     st_q  [NW];
    // index map: size, addr lo, addr hi, rld size, rld lo, rld hi
    udc_regfile #(.N(NW)) u_store (
        .clock (clock),
        .rst   (rst),
        .we    (st_we),
        .wdata (st_wd),
        .q     (st_q)
    );

    udc_buf_if #(.W(40)) b_in ();
    udc_buf_if #(.W(40)) b_out ();
    udc_skid #(.W(40)) u_skid (
        .clock (clock),
        .rst   (rst),
        .in_p  (b_in.dst),
        .out_p (b_out.src)
    );

    // ****************************************
    // control state
    // ****************************************
    udc_state_e state_reg, state_next;
    udc_opts_s  opts_reg, opts_next, opts_sw_reg, opts_sw_next;
    logic       run_reg, run_next, halt_reg, halt_next;
    logic       rel_reg, rel_next, ofl_reg, ofl_next;
    logic       men_reg, men_next, lost_reg, lost_next;
    udc_word_t  cnt_reg, cnt_next;
    udc_word_t  pkt_reg, pkt_next;
    logic       wr_ctrl, finish, swap, start;
    udc_word_t  left;
    logic [31:0] cur_addr;

    assign left     = st_q[0] - cnt_reg;
    assign cur_addr = {st_q[2], st_q[1]} + {16'h0000, cnt_reg};
    assign wr_ctrl  = reg_wr && (reg_addr == `UDC_OFF_CTRL);

    always_comb begin
        state_next   = state_reg;
        opts_next    = opts_reg;
        opts_sw_next = opts_sw_reg;
        run_next     = run_reg;
        halt_next    = halt_reg;
        rel_next     = rel_reg;
        ofl_next     = ofl_reg;
        men_next     = men_reg;
        lost_next    = lost_reg;
        cnt_next     = cnt_reg;
        pkt_next     = pkt_reg;
        finish       = 1'b0;
        swap         = 1'b0;
        start        = 1'b0;
        // software writes to control; reserved bits are dropped
        if (wr_ctrl) begin
            opts_sw_next = {reg_wdata[`UDC_BIT_SHORT],
                            reg_wdata[`UDC_BIT_CHAIN],
                            reg_wdata[`UDC_BIT_END]};
            halt_next = reg_wdata[`UDC_BIT_HALT];
            rel_next  = reg_wdata[`UDC_BIT_RELOAD];
            men_next  = reg_wdata[`UDC_BIT_MISS_EN];
            if (reg_wdata[`UDC_BIT_OFLOW]) begin
                ofl_next = 1'b0;
            end
            if (reg_wdata[`UDC_BIT_RUN] && !run_reg) begin
                start = 1'b1;
            end else if (!reg_wdata[`UDC_BIT_RUN]) begin
                run_next = 1'b0;
            end
        end
        if (reg_wr && reg_addr == `UDC_OFF_COUNT) begin
            cnt_next = reg_wdata;
        end
        if (start) begin
            run_next  = 1'b1;
            opts_next = {reg_wdata[`UDC_BIT_SHORT],
                         reg_wdata[`UDC_BIT_CHAIN],
                         reg_wdata[`UDC_BIT_END]};
            cnt_next  = `UDC_RST_WORD;
            pkt_next  = `UDC_RST_WORD;
        end
        unique case (state_reg)
            UDC_IDLE: begin
                if (start) state_next = UDC_MOVE;
            end
            UDC_MOVE: begin
                if (!run_next || halt_next) begin
                    state_next = UDC_IDLE;
                end else begin
                    if (ep_valid && b_in.ready) begin
                        cnt_next = cnt_reg + `UDC_ONE_BYTE;
                        pkt_next = pkt_reg + `UDC_ONE_BYTE;
                    end
                    if (ep_pkt_end && !IS_IN && !opts_reg.chain
                        && ep_pkt_len > left) begin
                        ofl_next = 1'b1;
                    end
                    if (ep_pkt_end) pkt_next = `UDC_RST_WORD;
                    if (cnt_next >= st_q[0]) begin
                        finish = 1'b1;
                        if (IS_IN && opts_reg.short_pkt
                            && pkt_next == 16'(MAX_PKT)) begin
                            state_next = UDC_ZLP;
                        end
                    end
                end
            end
            UDC_ZLP: begin
                state_next = UDC_IDLE;
            end
            default: state_next = UDC_IDLE;
        endcase
        // missed frame handled only on the lost flag's rising edge
        if (frame_missed && !lost_reg) begin
            lost_next = 1'b1;
            if (men_reg && run_reg) begin
                run_next   = 1'b0;
                state_next = UDC_IDLE;
                finish     = 1'b0;
            end
        end else if (ep_pkt_end) begin
            lost_next = 1'b0;
        end
        if (state_reg == UDC_ZLP) finish = 1'b1;
        if (finish && state_next != UDC_ZLP) begin
            if (rel_reg) begin
                swap       = 1'b1;
                opts_next  = opts_sw_reg;
                cnt_next   = `UDC_RST_WORD;
                pkt_next   = `UDC_RST_WORD;
                state_next = UDC_MOVE;
            end else begin
                run_next   = 1'b0;
                state_next = UDC_IDLE;
            end
        end
    end

    // storage write: software write or reload exchange
    always_comb begin
        for (int i = 0; i < NW; i++) begin
            st_we[i] = swap || (reg_wr
                && reg_addr == (i < 3 ? 3'(i + 1) : 3'(i + 2)));
            st_wd[i] = swap ? st_q[(i + 3) % NW] : reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg   <= UDC_IDLE;
            opts_reg    <= '0;
            opts_sw_reg <= '0;
            run_reg     <= `UDC_RST_BIT;
            halt_reg    <= `UDC_RST_BIT;
            rel_reg     <= `UDC_RST_BIT;
            ofl_reg     <= `UDC_RST_BIT;
            men_reg     <= `UDC_RST_BIT;
            lost_reg    <= `UDC_RST_BIT;
            cnt_reg     <= `UDC_RST_WORD;
            pkt_reg     <= `UDC_RST_WORD;
        end else begin
            state_reg   <= state_next;
            opts_reg    <= opts_next;
            opts_sw_reg <= opts_sw_next;
            run_reg     <= run_next;
            halt_reg    <= halt_next;
            rel_reg     <= rel_next;
            ofl_reg     <= ofl_next;
            men_reg     <= men_next;
            lost_reg    <= lost_next;
            cnt_reg     <= cnt_next;
            pkt_reg     <= pkt_next;
        end
    end

    // ****************************************
    // data path through the buffer
    // ****************************************
    assign b_in.valid  = ep_valid && state_reg == UDC_MOVE;
    assign b_in.data   = {cur_addr, ep_data};
    assign b_out.ready = mem_ready || !mem_valid;

    logic        mv_next, ecc_next, rdy_next, busy_next;
    logic [7:0]  md_next;
    logic [31:0] ma_next;
    udc_word_t   rd_next;

    // outputs registered so every top output leaves a flip-flop
    always_comb begin
        mv_next   = mem_valid;
        md_next   = mem_data;
        ma_next   = mem_addr;
        if (b_out.ready) begin
            mv_next = b_out.valid;
            md_next = b_out.data[7:0];
            ma_next = b_out.data[39:8];
        end
        ecc_next  = (state_reg == UDC_ZLP);
        rdy_next  = state_next == UDC_MOVE && b_in.ready;
        busy_next = run_next;
        rd_next   = `UDC_RST_WORD;
        if (reg_rd) begin
            unique case (reg_addr)
                `UDC_OFF_CTRL: rd_next = {7'h00, lost_reg, men_reg,
                    opts_sw_reg, ofl_reg, rel_reg, halt_reg, run_reg};
                `UDC_OFF_SIZE:       rd_next = st_q[0];
                `UDC_OFF_ADDR_LO:    rd_next = st_q[1];
                `UDC_OFF_ADDR_HI:    rd_next = st_q[2];
                `UDC_OFF_COUNT:      rd_next = cnt_reg;
                `UDC_OFF_RELOAD_SZ:  rd_next = st_q[3];
                `UDC_OFF_RELOAD_LO:  rd_next = st_q[4];
                `UDC_OFF_RELOAD_HI:  rd_next = st_q[5];
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mem_valid      <= 1'b0;
            mem_data       <= 8'h00;
            mem_addr       <= 32'h0000_0000;
            ep_count_clear <= 1'b0;
            ep_ready       <= 1'b0;
            busy           <= 1'b0;
            reg_rdata      <= `UDC_RST_WORD;
        end else begin
            mem_valid      <= mv_next;
            mem_data       <= md_next;
            mem_addr       <= ma_next;
            ep_count_clear <= ecc_next;
            ep_ready       <= rdy_next;
            busy           <= busy_next;
            reg_rdata      <= rd_next;
        end
    end
endmodule : udc_channel

// >>> udc_channel_props.sv
`timescale 1ns/1ps
// ****************************************
// port level checks for one dma channel
// ****************************************
module udc_channel_props #(
    parameter bit IS_IN   = 1'b1,
    parameter int MAX_PKT = 64
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        ep_valid,
    input wire logic [7:0]  ep_data,
    input wire logic        ep_ready,
    input wire logic        ep_pkt_end,
    input wire logic [15:0] ep_pkt_len,
    input wire logic        frame_missed,
    input wire logic        ep_count_clear,
    input wire logic        mem_valid,
    input wire logic [7:0]  mem_data,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ready,
    input wire logic        busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // shadow of the error-on-missing bit, tracked from control writes
    logic miss_en_reg;
    logic miss_en_next;
    always_comb begin
        miss_en_next = (reg_wr && reg_addr == 3'h0) ? reg_wdata[7]
                                                    : miss_en_reg;
    end
    always_ff @(posedge clock) begin
        miss_en_reg <= rst ? 1'b0 : miss_en_next;
    end

    // a clear that also starts the channel could see a fresh overflow
    sequence s_flag_clr;
        reg_wr && reg_addr == 3'h0 && reg_wdata[3] && !reg_wdata[0]
            && !busy && !ep_pkt_end;
    endsequence
    sequence s_ctrl_rd;
        reg_rd && reg_addr == 3'h0 && !reg_wr;
    endsequence

    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero without a read");
    chk_rsvd_zero: assert property (s_ctrl_rd |=> reg_rdata[15:9] == 7'h00)
        else $error("reserved control bits read nonzero");
    chk_mem_hold: assert property (mem_valid && !mem_ready |=>
        mem_valid && $stable(mem_data) && $stable(mem_addr))
        else $error("memory request changed while stalled");
    chk_start_busy: assert property (reg_wr && reg_addr == 3'h0 &&
        reg_wdata[0] && !busy && !frame_missed |=> busy)
        else $error("run write did not start channel");
    chk_stop_busy: assert property (reg_wr && reg_addr == 3'h0 &&
        !reg_wdata[0] |=> !busy)
        else $error("run cleared but channel still busy");
    chk_miss_halt: assert property (miss_en_reg && busy
        && $rose(frame_missed)
        |-> ##[1:3] !busy)
        else $error("missed frame did not halt channel");
    chk_run_readback: assert property (s_ctrl_rd |=>
        reg_rdata[0] == $past(busy))
        else $error("run bit readback differs from busy");
    chk_flag_clear: assert property (s_flag_clr ##[1:2] s_ctrl_rd |=>
        !reg_rdata[3])
        else $error("overflow flag survived a clear");
endmodule : udc_channel_props

bind udc_channel udc_channel_props #(.IS_IN(IS_IN), .MAX_PKT(MAX_PKT))
    u_props (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ep_valid(ep_valid), .ep_data(ep_data), .ep_ready(ep_ready),
        .ep_pkt_end(ep_pkt_end), .ep_pkt_len(ep_pkt_len),
        .frame_missed(frame_missed), .ep_count_clear(ep_count_clear),
        .mem_valid(mem_valid), .mem_data(mem_data), .mem_addr(mem_addr),
        .mem_ready(mem_ready), .busy(busy));

// >>> udc_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// processor memory stand-in, stalls 1 in 4
// ****************************************
module udc_mem_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        mem_valid,
    input  wire logic [7:0]  mem_data,
    input  wire logic [31:0] mem_addr,
    output logic             mem_ready
);
    logic [1:0]  tick_reg;
    logic [31:0] addr_q [$];
    logic [7:0]  data_q [$];

    // periodic stall so the held-request path is exercised
    assign mem_ready = (tick_reg != 2'h3);
    always_ff @(posedge clock) begin
        tick_reg <= rst ? 2'h0 : tick_reg + 2'h1;
        if (!rst && mem_valid && mem_ready) begin
            addr_q.push_back(mem_addr);
            data_q.push_back(mem_data);
        end
    end
endmodule : udc_mem_model

// >>> test_usb_endpoint_dma_channel.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    tests_run++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("BAD %s exp %h got %h", nm, exp, got); \
    end
module test_usb_endpoint_dma_channel;
    logic clock, rst, reg_wr, reg_rd, ep_valid, ep_pkt_end, frame_missed;
    logic [2:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, ep_pkt_len;
    logic [7:0]  ep_data, mem_data;
    logic [31:0] mem_addr;
    logic ep_ready, ep_count_clear, mem_valid, mem_ready, busy;
    logic ecc_in, busy_in;
    int errors = 0;
    int tests_run = 0;

    udc_channel #(.IS_IN(1'b0)) uut (.clock(clock), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ep_valid(ep_valid), .ep_data(ep_data), .ep_ready(ep_ready),
        .ep_pkt_end(ep_pkt_end), .ep_pkt_len(ep_pkt_len),
        .frame_missed(frame_missed), .ep_count_clear(ep_count_clear),
        .mem_valid(mem_valid), .mem_data(mem_data), .mem_addr(mem_addr),
        .mem_ready(mem_ready), .busy(busy));
    // in-direction twin, only there for the zero length packet path
    udc_channel #(.IS_IN(1'b1), .MAX_PKT(3)) uut_in (.clock(clock),
        .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(),
        .ep_valid(ep_valid), .ep_data(ep_data), .ep_ready(),
        .ep_pkt_end(ep_pkt_end), .ep_pkt_len(ep_pkt_len),
        .frame_missed(frame_missed), .ep_count_clear(ecc_in),
        .mem_valid(), .mem_data(), .mem_addr(),
        .mem_ready(mem_ready), .busy(busy_in));
    udc_mem_model u_mem (.clock(clock), .rst(rst), .mem_valid(mem_valid),
        .mem_data(mem_data), .mem_addr(mem_addr), .mem_ready(mem_ready));

    // ****************************************
    // bus and stream helpers
    // ****************************************
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr
    // read data stands one cycle, so sample at the next falling edge
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic chk_reg(input logic [2:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        `CHK("register", e, d)
    endtask : chk_reg
    // valid is left high between bytes; ep_idle drops it
    task automatic push(input logic [7:0] b);
        int n;
        @(negedge clock);
        ep_valid = 1'b1;
        ep_data = b;
        n = 0;
        while (ep_ready !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        if (n >= 50) errors++;
        @(posedge clock);
    endtask : push
    task automatic ep_idle();
        @(negedge clock);
        ep_valid = 1'b0;
    endtask : ep_idle
    task automatic pkt(input logic [15:0] len);
        @(negedge clock);
        ep_pkt_end = 1'b1;
        ep_pkt_len = len;
        @(negedge clock);
        ep_pkt_end = 1'b0;
    endtask : pkt
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        if (n >= 100) errors++;
    endtask : wait_idle
    task automatic wait_mem(input int k);
        int n;
        n = 0;
        while (u_mem.addr_q.size() < k && n < 100) begin
            @(negedge clock);
            n++;
        end
        if (n >= 100) errors++;
    endtask : wait_mem

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        chk_reg(3'h0, 16'h0000);
        for (int i = 1; i < 8; i++) wr(i[2:0], 16'h1100 + 16'(i));
        for (int i = 1; i < 8; i++) chk_reg(i[2:0], 16'h1100 + 16'(i));
        wr(3'h0, 16'h0070);
        chk_reg(3'h0, 16'h0070);
        wr(3'h0, 16'h0000);
        $display("done regs");
    endtask : t_regs
    task automatic t_xfer();
        wr(3'h1, 16'h0003);
        wr(3'h2, 16'h0100);
        wr(3'h3, 16'h0002);
        wr(3'h0, 16'h0041); // short packet control on for the in twin
        `CHK("busy", 1'b1, busy)
        `CHK("ready", 1'b1, ep_ready)
        for (int i = 0; i < 3; i++) push(8'ha1 + 8'(i));
        ep_idle();
        `CHK("zlp", 1'b0, ecc_in)
        @(negedge clock);
        `CHK("zlp", 1'b1, ecc_in)
        `CHK("zlp", 1'b0, ep_count_clear)
        `CHK("busy in", 1'b0, busy_in)
        wait_idle();
        `CHK("busy", 1'b0, busy)
        chk_reg(3'h4, 16'h0003);
        wait_mem(3);
        for (int i = 0; i < 3; i++) begin
            `CHK("addr", 32'h00020100 + 32'(i), u_mem.addr_q[i])
            `CHK("data", 8'ha1 + 8'(i), u_mem.data_q[i])
        end
        $display("done xfer");
    endtask : t_xfer
    task automatic t_reload();
        wr(3'h1, 16'h0002);
        wr(3'h2, 16'h0300);
        wr(3'h3, 16'h0000);
        wr(3'h5, 16'h0001);
        wr(3'h6, 16'h0200);
        wr(3'h7, 16'h0001);
        wr(3'h0, 16'h0005);
        push(8'hb0);
        push(8'hb1);
        ep_idle();
        wait_mem(5);
        `CHK("busy", 1'b1, busy)
        chk_reg(3'h1, 16'h0001);
        chk_reg(3'h5, 16'h0002);
        chk_reg(3'h6, 16'h0300);
        push(8'hb2);
        ep_idle();
        wait_mem(6);
        `CHK("addr", 32'h00010200, u_mem.addr_q[5])
        wr(3'h0, 16'h0000);
        `CHK("busy", 1'b0, busy)
        $display("done reload");
    endtask : t_reload
    task automatic t_ovf();
        logic [15:0] d;
        wr(3'h1, 16'h0002);
        wr(3'h0, 16'h0001);
        wr(3'h0, 16'h0021); // chain raised mid-run must be ignored
        pkt(16'h0005);
        wr(3'h0, 16'h0000);
        rd(3'h0, d);
        `CHK("overflow", 1'b1, d[3])
        wr(3'h0, 16'h0008);
        rd(3'h0, d);
        `CHK("overflow", 1'b0, d[3])
        wr(3'h0, 16'h0021);
        pkt(16'h0005);
        rd(3'h0, d);
        `CHK("overflow", 1'b0, d[3])
        wr(3'h0, 16'h0000);
        $display("done ovf");
    endtask : t_ovf
    task automatic t_miss();
        logic [15:0] d;
        wr(3'h1, 16'h0010);
        wr(3'h0, 16'h0081);
        frame_missed = 1'b1;
        wait_idle();
        frame_missed = 1'b0;
        `CHK("busy", 1'b0, busy)
        rd(3'h0, d);
        `CHK("lost", 1'b1, d[8])
        $display("done miss");
    endtask : t_miss

    task automatic tally_and_finish();
        $display("checks %0d bad %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // clock, reset, sequence, watchdog
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        {rst, reg_wr, reg_rd, ep_valid, ep_pkt_end, frame_missed} = 6'h20;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        ep_data = 8'h00;
        ep_pkt_len = 16'h0000;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        t_regs();
        t_xfer();
        t_reload();
        t_ovf();
        t_miss();
        tally_and_finish();
    end
    // whole run is well under two hundred cycles; ten thousand means a hang
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule : test_usb_endpoint_dma_channel
